// *** hw/tnc_buf2.sv ***
/*
  Two-entry buffer on the resampled sample path. Assumes a valid/ready
  source on the interface side and a sink that may stall.
*/
`timescale 1ns/10ps
`default_nettype none
module tnc_buf2
  import tnc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  tnc_stream_if.snk in_s,
  output logic out_valid,
  output logic [23:0] out_data,
  input wire logic out_ready
);
  logic [23:0] mem_r [2];
  logic rd_r;
  logic wr_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  assign in_s.ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rd_r];
  assign push = in_s.valid & in_s.ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_r[0] <= 24'h00_0000;
      mem_r[1] <= 24'h00_0000;
    end
    else if (push)
      mem_r[wr_r] <= in_s.data;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      if (push)
        wr_r <= ~wr_r;
      if (pop)
        rd_r <= ~rd_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  AST_BUF_NO_OVERRUN: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cnt_r == 2'h2 && !out_ready) |=> (cnt_r == 2'h2 && !in_s.ready))
    else $error("buffer lost or refused wrongly while full");
endmodule : tnc_buf2
`default_nettype wire

// *** hw/tnc_defines.svh ***
/*
  Offsets, field positions, reset values and cycle counts of the timing
  oscillator and timing error block. Assumes byte addresses equal four
  times the register index.
*/
`ifndef TNC_DEFINES_SVH
`define TNC_DEFINES_SVH
`define TNC_IDX_CTRL 6'h0b
`define TNC_IDX_CFREQ 6'h0c
`define TNC_IDX_POFS 6'h0d
`define TNC_IDX_FSTB 6'h0e
`define TNC_IDX_PSTB 6'h0f
`define TNC_IDX_RMODE 6'h10
`define TNC_IDX_STAT 6'h11
`define TNC_IDX_DIV 6'h12
`define TNC_IDX_TERR 6'h13
`define TNC_CTRL_LOAD 0
`define TNC_CTRL_CLR 1
`define TNC_CTRL_OFS_EN 2
`define TNC_CTRL_OFSW_LO 3
`define TNC_CTRL_SYNC_EN 5
`define TNC_DIV_REF_LO 0
`define TNC_DIV_NCO_LO 16
`define TNC_RST_WORD 32'h0000_0000
`define TNC_CYC_BYPASS 5'h00
`define TNC_CYC_POLY 5'h06
`define TNC_CYC_POLY_HB1 5'h0d
`define TNC_CYC_POLY_HB2 5'h17
`define TNC_CYC_HB1 5'h07
`define TNC_CYC_HB2 5'h11
`define TNC_TE_BITS 5'h10
`endif

// *** hw/tnc_pkg.sv ***
/*
  Types shared by the timing oscillator block. Assumes nothing.
*/
package tnc_pkg;
  typedef enum logic [2:0] {
    TNC_RM_BYPASS = 3'b000,
    TNC_RM_POLY = 3'b001,
    TNC_RM_POLY_HB1 = 3'b010,
    TNC_RM_POLY_HB2 = 3'b011,
    TNC_RM_HB1 = 3'b100,
    TNC_RM_HB2 = 3'b101
  } tnc_rmode_t;
  typedef enum logic [1:0] {
    TNC_ST_IDLE = 2'b00,
    TNC_ST_CALC = 2'b01,
    TNC_ST_EMIT = 2'b10
  } tnc_state_t;
endpackage : tnc_pkg

// *** hw/tnc_stream_if.sv ***
/*
  Valid/ready carrier between the resampler sequencer and its buffer.
  Assumes one clock for both ends.
*/
`timescale 1ns/10ps
`default_nettype none
interface tnc_stream_if;
  logic valid;
  logic ready;
  logic [23:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : tnc_stream_if
`default_nettype wire

// *** hw/tnc_ted.sv ***
/*
  Timing error detector: two preloaded down counters, one on oscillator
  carries, one on reference clock rising edges, plus serial output.
  Assumes the reference clock level is synchronous to clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tnc_defines.svh"
module tnc_ted
  import tnc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic nco_tick,
  input wire logic ref_lvl,
  input wire logic [11:0] nco_div,
  input wire logic [11:0] ref_div,
  output logic [15:0] te_val,
  output logic te_sdata,
  output logic te_sframe
);
  logic ref_prev_r;
  logic [11:0] nco_cnt_r;
  logic [11:0] ref_cnt_r;
  logic [15:0] te_r;
  logic [15:0] sh_r;
  logic [4:0] bits_r;
  logic ref_tick;
  logic ref_term;

  assign ref_tick = ref_lvl & ~ref_prev_r;
  assign ref_term = ref_tick && (ref_cnt_r == 12'h000);
  assign te_val = te_r;
  assign te_sdata = sh_r[15];
  assign te_sframe = (bits_r != 5'h00);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      ref_prev_r <= 1'b0;
    else
      ref_prev_r <= ref_lvl;
  end

  // Counters reload at terminal count rather than wrapping freely
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      nco_cnt_r <= 12'h000;
      ref_cnt_r <= 12'h000;
    end
    else
    begin
      if (nco_tick)
        nco_cnt_r <= (nco_cnt_r == 12'h000) ? nco_div : nco_cnt_r - 12'h001;
      if (ref_tick)
        ref_cnt_r <= ref_term ? ref_div : ref_cnt_r - 12'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      te_r <= 16'h0000;
    else if (ref_term)
      te_r <= {4'h0, nco_cnt_r} - {4'h0, ref_cnt_r};
  end

  // A new sample restarts the frame; a slow reference never overlaps it
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sh_r <= 16'h0000;
      bits_r <= 5'h00;
    end
    else if (ref_term)
    begin
      sh_r <= {4'h0, nco_cnt_r} - {4'h0, ref_cnt_r};
      bits_r <= `TNC_TE_BITS;
    end
    else if (bits_r != 5'h00)
    begin
      sh_r <= {sh_r[14:0], 1'b0};
      bits_r <= bits_r - 5'h01;
    end
  end

  AST_TE_SAMPLE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ref_term |=> (te_r == $past({4'h0, nco_cnt_r})) ##0 te_sframe [*8])
    else $error("timing error not sampled or frame not started");
endmodule : tnc_ted
`default_nettype wire

// *** hw/tnc_top.sv ***
/*
  Timing oscillator with register slave, serial offset input, resampler
  cycle sequencer and timing error detector. Assumes an Avalon-MM master
  with byte addresses and a synchronous reference clock level.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tnc_defines.svh"
module tnc_top
  import tnc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ofs_ser_en,
  input wire logic ofs_ser_data,
  input wire logic ext_sync,
  input wire logic timing_reference_clock,
  input wire logic smp_in_valid,
  input wire logic [15:0] smp_in_data,
  output logic smp_in_ready,
  output logic smp_out_valid,
  output logic [23:0] smp_out_data,
  input wire logic smp_out_ready,
  output logic nco_sample_pulse,
  output logic [7:0] nco_phase,
  output logic te_ser_data,
  output logic te_ser_frame
);
  logic ack_r;
  logic req;
  logic wr_go;
  logic [5:0] idx;
  logic [31:0] rdata_r;
  logic [31:0] ctrl_r;
  logic [31:0] cfreq_r;
  logic [7:0] pofs_r;
  logic [31:0] div_r;
  tnc_rmode_t rmode_r;
  logic fstb;
  logic pstb;
  logic [31:0] ofs_sh_r;
  logic [5:0] ofs_cnt_r;
  logic [31:0] ofs_pend_r;
  logic [5:0] ofs_width;
  logic [31:0] freq_act_r;
  logic [7:0] phase_act_r;
  logic [31:0] freq_new;
  logic [31:0] acc_r;
  logic [32:0] acc_sum;
  logic pulse_r;
  logic [7:0] phase_r;
  logic do_clr;
  logic do_sync;
  logic [15:0] te_val;
  tnc_state_t st_r;
  logic [4:0] cyc_r;
  logic [2:0] rep_r;
  logic [15:0] smp_r;
  logic pend_r;
  logic poly;
  logic take;
  logic emit;
  tnc_stream_if seq_s ();

  // Register slave answers one cycle after the request appears
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign wr_go = avs_write & ack_r;
  assign idx = avs_address[7:2];
  assign avs_readdata = rdata_r;
  assign fstb = wr_go && (idx == `TNC_IDX_FSTB);
  assign pstb = wr_go && (idx == `TNC_IDX_PSTB);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      ack_r <= 1'b0;
    else
      ack_r <= req & ~ack_r;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      rdata_r <= `TNC_RST_WORD;
    else if (avs_read && !ack_r)
    begin
      if (idx == `TNC_IDX_CTRL)
        rdata_r <= {26'h000_0000, ctrl_r[5:0]};
      else if (idx == `TNC_IDX_CFREQ)
        rdata_r <= cfreq_r;
      else if (idx == `TNC_IDX_POFS)
        rdata_r <= {24'h00_0000, pofs_r};
      else if (idx == `TNC_IDX_RMODE)
        rdata_r <= {29'h0000_0000, rmode_r};
      else if (idx == `TNC_IDX_STAT)
        rdata_r <= acc_r;
      else if (idx == `TNC_IDX_DIV)
        rdata_r <= {4'h0, div_r[27:16], 4'h0, div_r[11:0]};
      else if (idx == `TNC_IDX_TERR)
        rdata_r <= {16'h0000, te_val};
      else
        rdata_r <= `TNC_RST_WORD;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_r <= `TNC_RST_WORD;
      cfreq_r <= `TNC_RST_WORD;
      pofs_r <= 8'h00;
      div_r <= `TNC_RST_WORD;
      rmode_r <= TNC_RM_BYPASS;
    end
    else if (wr_go)
    begin
      if (idx == `TNC_IDX_CTRL)
        ctrl_r <= {26'h000_0000, avs_writedata[5:0]};
      else if (idx == `TNC_IDX_CFREQ)
        cfreq_r <= avs_writedata;
      else if (idx == `TNC_IDX_POFS)
        pofs_r <= avs_writedata[7:0];
      else if (idx == `TNC_IDX_DIV)
        div_r <= {4'h0, avs_writedata[27:16], 4'h0, avs_writedata[11:0]};
      else if (idx == `TNC_IDX_RMODE && avs_writedata[2:0] <= 3'h5)
        rmode_r <= tnc_rmode_t'(avs_writedata[2:0]);
    end
  end

  // Serial offset word, MSB first, left-aligned; ofs_width is the bit count less one
  assign ofs_width = {1'b0, ctrl_r[`TNC_CTRL_OFSW_LO + 1], ctrl_r[`TNC_CTRL_OFSW_LO], 3'h7};

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ofs_sh_r <= `TNC_RST_WORD;
      ofs_cnt_r <= 6'h00;
      ofs_pend_r <= `TNC_RST_WORD;
    end
    else if (ofs_ser_en)
    begin
      ofs_sh_r <= {ofs_sh_r[30:0], ofs_ser_data};
      if (ofs_cnt_r == ofs_width)
      begin
        ofs_cnt_r <= 6'h00;
        ofs_pend_r <= {ofs_sh_r[30:0], ofs_ser_data} << (6'h1f - ofs_width);
      end
      else
        ofs_cnt_r <= ofs_cnt_r + 6'h01;
    end
  end

  assign freq_new = cfreq_r + (ctrl_r[`TNC_CTRL_OFS_EN] ? ofs_pend_r : `TNC_RST_WORD);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      freq_act_r <= `TNC_RST_WORD;
      phase_act_r <= 8'h00;
    end
    else
    begin
      if (fstb)
        freq_act_r <= freq_new;
      if (pstb)
        phase_act_r <= pofs_r;
    end
  end

  // Accumulator only; no sine or cosine table follows it
  assign acc_sum = {1'b0, acc_r} + {1'b0, freq_act_r};
  assign do_clr = ctrl_r[`TNC_CTRL_CLR];
  assign do_sync = ctrl_r[`TNC_CTRL_SYNC_EN] & ext_sync;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_r <= `TNC_RST_WORD;
      pulse_r <= 1'b0;
    end
    else if (do_clr)
    begin
      acc_r <= `TNC_RST_WORD;
      pulse_r <= 1'b0;
    end
    else if (do_sync)
    begin
      acc_r <= `TNC_RST_WORD;
      pulse_r <= 1'b0;
    end
    else if (fstb && ctrl_r[`TNC_CTRL_LOAD])
    begin
      acc_r <= freq_new;
      pulse_r <= 1'b0;
    end
    else if (pstb && ctrl_r[`TNC_CTRL_LOAD])
    begin
      acc_r <= {pofs_r, 24'h00_0000};
      pulse_r <= 1'b0;
    end
    else
    begin
      acc_r <= acc_sum[31:0];
      pulse_r <= acc_sum[32];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      phase_r <= 8'h00;
    else
      phase_r <= acc_r[31:24] + phase_act_r;
  end

  assign nco_sample_pulse = pulse_r;
  assign nco_phase = phase_r;

  // Resampler sequencer; the filter arithmetic itself is not modelled
  assign poly = (rmode_r == TNC_RM_POLY) || (rmode_r == TNC_RM_POLY_HB1)
    || (rmode_r == TNC_RM_POLY_HB2);
  assign smp_in_ready = (st_r == TNC_ST_IDLE);
  assign take = smp_in_valid & smp_in_ready;
  assign seq_s.valid = (st_r == TNC_ST_EMIT) && (!poly || pend_r);
  assign seq_s.data = {phase_r, smp_r};
  assign emit = seq_s.valid & seq_s.ready;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= TNC_ST_IDLE;
      cyc_r <= 5'h00;
      rep_r <= 3'h0;
      smp_r <= 16'h0000;
    end
    else
    begin
      case (st_r)
        TNC_ST_IDLE:
        begin
          if (take)
          begin
            smp_r <= smp_in_data;
            case (rmode_r)
              TNC_RM_POLY: cyc_r <= `TNC_CYC_POLY;
              TNC_RM_POLY_HB1: cyc_r <= `TNC_CYC_POLY_HB1;
              TNC_RM_POLY_HB2: cyc_r <= `TNC_CYC_POLY_HB2;
              TNC_RM_HB1: cyc_r <= `TNC_CYC_HB1;
              TNC_RM_HB2: cyc_r <= `TNC_CYC_HB2;
              default: cyc_r <= `TNC_CYC_BYPASS;
            endcase
            // Polyphase modes emit once per oscillator pulse, not per factor
            rep_r <= (rmode_r == TNC_RM_HB1) ? 3'h2 : (rmode_r == TNC_RM_HB2) ? 3'h4 : 3'h1;
            st_r <= (rmode_r == TNC_RM_BYPASS) ? TNC_ST_EMIT : TNC_ST_CALC;
          end
        end
        TNC_ST_CALC:
        begin
          cyc_r <= cyc_r - 5'h01;
          if (cyc_r == 5'h01)
            st_r <= TNC_ST_EMIT;
        end
        TNC_ST_EMIT:
        begin
          if (emit)
          begin
            rep_r <= rep_r - 3'h1;
            if (rep_r == 3'h1)
              st_r <= TNC_ST_IDLE;
          end
        end
        default: st_r <= TNC_ST_IDLE;
      endcase
    end
  end

  // A pulse arriving as the pending one is used is kept
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      pend_r <= 1'b0;
    else if (pulse_r)
      pend_r <= 1'b1;
    else if (emit && poly)
      pend_r <= 1'b0;
  end

  tnc_buf2 u_buf (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_s(seq_s),
    .out_valid(smp_out_valid),
    .out_data(smp_out_data),
    .out_ready(smp_out_ready)
  );

  tnc_ted u_ted (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .nco_tick(pulse_r),
    .ref_lvl(timing_reference_clock),
    .nco_div(div_r[`TNC_DIV_NCO_LO +: 12]),
    .ref_div(div_r[`TNC_DIV_REF_LO +: 12]),
    .te_val(te_val),
    .te_sdata(te_ser_data),
    .te_sframe(te_ser_frame)
  );

  sequence s_poly_take;
    take && rmode_r == TNC_RM_POLY;
  endsequence
  sequence s_poly_calc;
    (st_r == TNC_ST_CALC) [*6] ##1 (st_r == TNC_ST_EMIT);
  endsequence

  AST_POLY_CYCLES: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_poly_take |=> s_poly_calc)
    else $error("polyphase compute time is not six clocks");
  AST_BYPASS_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (take && rmode_r == TNC_RM_BYPASS) |=> (st_r == TNC_ST_EMIT))
    else $error("bypass did not emit at once");
  AST_POLY_RATE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_r == TNC_ST_EMIT && poly && !pend_r) |-> !seq_s.valid)
    else $error("polyphase output without oscillator pulse");
  AST_CARRY_PULSE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!do_clr && !do_sync && !fstb && !pstb && acc_sum[32]) |=> nco_sample_pulse)
    else $error("carry did not give a sample pulse");
  AST_CLEAR_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
    do_clr |=> (acc_r == 32'h0000_0000 && !nco_sample_pulse))
    else $error("accumulator not cleared");
  AST_EXT_SYNC: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (do_sync && !do_clr) |=> (acc_r == 32'h0000_0000))
    else $error("external sync ignored");
  AST_FREQ_STROBE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    fstb |=> (freq_act_r == $past(freq_new)) ##1 $stable(freq_act_r) or fstb)
    else $error("frequency strobe did not transfer");
  AST_LOAD_UPDATE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (fstb && ctrl_r[`TNC_CTRL_LOAD] && !do_clr && !do_sync) |=> (acc_r == freq_act_r))
    else $error("load on update did not load");
  AST_BUS_ANSWER: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (req && !ack_r) |-> avs_waitrequest ##1 (!avs_waitrequest || !req))
    else $error("slave did not answer in one cycle");
endmodule : tnc_top
`default_nettype wire

// *** tb/tb_top.sv ***
/*
  Self-checking bench of the timing oscillator block. Assumes the far side
  model above and registers at byte address four times the index.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tnc_defines.svh"
module tb_top
  import tnc_pkg::*;
  ;
  logic clk_sys, arst_n, avs_read, avs_write, avs_waitrequest, ext_sync, stall;
  logic [7:0] avs_address, nco_phase, ref_half;
  logic [31:0] avs_writedata, avs_readdata, rd, last_out;
  logic ofs_ser_en, ofs_ser_data, timing_reference_clock, smp_in_valid, smp_in_ready;
  logic [15:0] smp_in_data, te_a, te_b;
  logic smp_out_valid, smp_out_ready, nco_sample_pulse, te_ser_data, te_ser_frame;
  logic [23:0] smp_out_data;
  int error_cnt = 0, n_tests = 0, cyc = 0, out_cnt = 0, p, len;
  tnc_top dut (.clk_sys(clk_sys), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ofs_ser_en(ofs_ser_en), .ofs_ser_data(ofs_ser_data), .ext_sync(ext_sync),
    .timing_reference_clock(timing_reference_clock), .smp_in_valid(smp_in_valid),
    .smp_in_data(smp_in_data), .smp_in_ready(smp_in_ready),
    .smp_out_valid(smp_out_valid), .smp_out_data(smp_out_data),
    .smp_out_ready(smp_out_ready), .nco_sample_pulse(nco_sample_pulse),
    .nco_phase(nco_phase), .te_ser_data(te_ser_data), .te_ser_frame(te_ser_frame));
  tnc_far_model far (.clk_sys(clk_sys), .arst_n(arst_n), .ref_half(ref_half),
    .stall(stall), .timing_reference_clock(timing_reference_clock),
    .smp_out_ready(smp_out_ready), .ofs_ser_en(ofs_ser_en), .ofs_ser_data(ofs_ser_data));
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Sampled at the falling edge so a transfer is seen before its edge lands
  always @(negedge clk_sys)
  begin
    if (smp_out_valid === 1'b1 && smp_out_ready === 1'b1)
    begin
      out_cnt++;
      last_out = {8'h00, smp_out_data};
    end
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      results();
    end
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge clk_sys);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rchk(input string nm, input logic [5:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0000_0000);
    chk(nm, exp, rd);
  endtask : rchk
  task automatic period(output int p);
    int n;
    n = 0;
    // Skip pulses still launched with the old frequency
    repeat (2) @(negedge clk_sys);
    while (nco_sample_pulse !== 1'b1 && n < 300)
    begin
      @(negedge clk_sys);
      n++;
    end
    p = 0;
    do
    begin
      @(negedge clk_sys);
      p++;
    end
    while (nco_sample_pulse !== 1'b1 && p < 300);
  endtask : period
  task automatic quiet(output int c);
    c = 0;
    repeat (40)
    begin
      @(negedge clk_sys);
      if (nco_sample_pulse !== 1'b0)
        c++;
    end
  endtask : quiet
  task automatic t_regs();
    rchk("ctrl reset", `TNC_IDX_CTRL, 32'h0000_0000);
    bus(1'b1, `TNC_IDX_CFREQ, 32'h1234_5678);
    rchk("center", `TNC_IDX_CFREQ, 32'h1234_5678);
    bus(1'b1, `TNC_IDX_POFS, 32'h0000_00a5);
    rchk("phase ofs", `TNC_IDX_POFS, 32'h0000_00a5);
    bus(1'b1, `TNC_IDX_DIV, 32'h0abc_0123);
    rchk("dividers", `TNC_IDX_DIV, 32'h0abc_0123);
    rchk("strobe", `TNC_IDX_FSTB, 32'h0000_0000);
    rchk("unmapped", 6'h3f, 32'h0000_0000);
    $display("done regs");
  endtask : t_regs
  task automatic t_nco();
    int c;
    bus(1'b1, `TNC_IDX_CFREQ, 32'h1000_0000);
    bus(1'b1, `TNC_IDX_CTRL, 32'h0000_0001);
    bus(1'b1, `TNC_IDX_FSTB, 32'h0000_0000);
    period(p);
    chk("period 16", 32'd16, p);
    bus(1'b1, `TNC_IDX_CTRL, 32'h0000_0002);
    quiet(c);
    chk("pulses cleared", 32'd0, c);
    bus(1'b1, `TNC_IDX_CTRL, 32'h0000_0020);
    ext_sync <= 1'b1;
    quiet(c);
    chk("pulses synced", 32'd0, c);
    @(posedge clk_sys);
    ext_sync <= 1'b0;
    bus(1'b1, `TNC_IDX_CTRL, 32'h0000_0004);
    far.shift_ofs(32'h1000_0000, 8);
    bus(1'b1, `TNC_IDX_FSTB, 32'h0000_0000);
    period(p);
    chk("period 8", 32'd8, p);
    bus(1'b1, `TNC_IDX_CTRL, 32'h0000_001c);
    far.shift_ofs(32'h7000_0000, 32);
    bus(1'b1, `TNC_IDX_FSTB, 32'h0000_0000);
    period(p);
    chk("period 2", 32'd2, p);
    bus(1'b1, `TNC_IDX_CTRL, 32'h0000_000c);
    far.shift_ofs(32'h3000_0000, 16);
    period(p);
    chk("pending", 32'd2, p);
    bus(1'b1, `TNC_IDX_FSTB, 32'h0000_0000);
    period(p);
    chk("period 4", 32'd4, p);
    $display("done nco");
  endtask : t_nco
  task automatic t_phase();
    bus(1'b1, `TNC_IDX_CTRL, 32'h0000_0002);
    bus(1'b1, `TNC_IDX_POFS, 32'h0000_0040);
    repeat (3) @(negedge clk_sys);
    chk("phase before", 32'h0, {24'h0, nco_phase});
    bus(1'b1, `TNC_IDX_PSTB, 32'h0000_0000);
    repeat (3) @(negedge clk_sys);
    chk("phase after", 32'h40, {24'h0, nco_phase});
    rchk("acc cleared", `TNC_IDX_STAT, 32'h0000_0000);
    $display("done phase");
  endtask : t_phase
  task automatic send(input logic [15:0] d, output int low);
    @(posedge clk_sys);
    smp_in_valid <= 1'b1;
    smp_in_data <= d;
    do @(negedge clk_sys); while (smp_in_ready !== 1'b1);
    @(posedge clk_sys);
    smp_in_valid <= 1'b0;
    low = 0;
    do
    begin
      @(negedge clk_sys);
      low++;
    end
    while (smp_in_ready !== 1'b1 && low < 400);
  endtask : send
  task automatic t_resamp();
    int cyc_tab[6] = '{0, 6, 13, 23, 7, 17};
    int cnt_tab[6] = '{1, 1, 1, 1, 2, 4};
    bus(1'b1, `TNC_IDX_RMODE, 32'h0000_0001);
    out_cnt = 0;
    // A pulse left pending by earlier tests is used by the first sample
    send(16'h5a5a, len);
    repeat (6) @(negedge clk_sys);
    chk("kept pulse out", 32'd1, out_cnt);
    out_cnt = 0;
    @(posedge clk_sys);
    smp_in_valid <= 1'b1;
    smp_in_data <= 16'h5a5a;
    @(posedge clk_sys);
    smp_in_valid <= 1'b0;
    repeat (60) @(negedge clk_sys);
    chk("no pulse no out", 32'd0, out_cnt);
    bus(1'b1, `TNC_IDX_CTRL, 32'h0000_000c);
    repeat (40) @(negedge clk_sys);
    chk("pulse out", 32'd1, out_cnt);
    for (int m = 0; m < 6; m++)
    begin
      bus(1'b1, `TNC_IDX_RMODE, m);
      out_cnt = 0;
      stall <= 1'b1;
      fork
        send(16'hc300 + m, len);
        repeat (60) @(posedge clk_sys);
      join_any
      @(posedge clk_sys);
      stall <= 1'b0;
      wait fork;
      repeat (6) @(negedge clk_sys);
      chk("outputs", cnt_tab[m], out_cnt);
      chk("busy cycles", 32'd1, len >= cyc_tab[m]);
      chk("sample", 32'hc300 + m, {16'h0, last_out[15:0]});
    end
    $display("done resamp");
  endtask : t_resamp
  task automatic get_te(output logic [15:0] v);
    int n;
    n = 0;
    while (te_ser_frame !== 1'b1 && n < 2000)
    begin
      @(negedge clk_sys);
      n++;
    end
    len = 0;
    while (te_ser_frame === 1'b1 && len < 40)
    begin
      v = {v[14:0], te_ser_data};
      len++;
      @(negedge clk_sys);
    end
    chk("frame len", 32'd16, len);
    rchk("te read", `TNC_IDX_TERR, {16'h0, v});
  endtask : get_te
  task automatic t_te();
    bus(1'b1, `TNC_IDX_DIV, 32'h00ff_0001);
    ref_half <= 8'd10;
    get_te(te_a);
    get_te(te_b);
    chk("te step", 32'd10, {24'h0, te_a[7:0] - te_b[7:0]});
    $display("done te");
  endtask : t_te
  initial
  begin
    arst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    ext_sync = 1'b0;
    smp_in_valid = 1'b0;
    smp_in_data = 16'h0;
    stall = 1'b0;
    ref_half = 8'h00;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_regs();
    t_nco();
    t_phase();
    t_resamp();
    t_te();
    results();
  end
endmodule : tb_top
`default_nettype wire

// *** tb/tnc_far_model.sv ***
/*
  Far side model: reference clock source, stalling sample sink and the
  loop filter's serial offset feed. Assumes controls change after rising edges.
*/
`timescale 1ns/10ps
`default_nettype none
module tnc_far_model
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] ref_half,
  input wire logic stall,
  output logic timing_reference_clock,
  output logic smp_out_ready,
  output logic ofs_ser_en,
  output logic ofs_ser_data
);
  logic [7:0] ref_cnt_r;
  // Reference holds its level while the half period is zero; reset leaves it low
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ref_cnt_r <= 8'h00;
      timing_reference_clock <= 1'b0;
    end
    else if (ref_half != 8'h00)
    begin
      if (ref_cnt_r == ref_half - 8'h01)
      begin
        ref_cnt_r <= 8'h00;
        timing_reference_clock <= ~timing_reference_clock;
      end
      else
        ref_cnt_r <= ref_cnt_r + 8'h01;
    end
  end
  assign smp_out_ready = ~stall;
  initial
  begin
    ofs_ser_en = 1'b0;
    ofs_ser_data = 1'b0;
  end
  // Filtered error fed back as offset word, MSB first
  task automatic shift_ofs(input logic [31:0] word, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      ofs_ser_en <= 1'b1;
      ofs_ser_data <= word[31-i];
    end
    @(posedge clk_sys);
    ofs_ser_en <= 1'b0;
    // Idle data is not held, so a design that samples late sees garbage
    ofs_ser_data <= ~word[32-n];
  endtask : shift_ofs
endmodule : tnc_far_model
`default_nettype wire
